// ==== verilog/aba_pkg.sv ====
// Shared constants and types of the address bus arbitration block
package aba_pkg;

	// ------------------------------------------------------------
	// Pin levels (all arbitration pins are active low)
	// ------------------------------------------------------------
	localparam logic PIN_ASSERTED = 1'b0;
	localparam logic PIN_NEGATED  = 1'b1;

	// ------------------------------------------------------------
	// Timing counts in bus clock cycles
	// ------------------------------------------------------------
	localparam int   GAP_W         = 2;
	localparam logic [GAP_W-1:0] GAP_AFTER_GRANT = 2'h1;
	localparam logic [GAP_W-1:0] GAP_NONE        = 2'h0;
	localparam logic [GAP_W-1:0] GAP_STEP        = 2'h1;

	// ------------------------------------------------------------
	// Pipeline depth limits
	// ------------------------------------------------------------
	localparam int PIPE_MIN     = 2;
	localparam int PIPE_MAX_DEF = 3;
	localparam int CNT_W        = 2;

	// ------------------------------------------------------------
	// Master state machine
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_REQ  = 4'h2,
		ST_OWN  = 4'h4,
		ST_REL  = 4'h8
	} aba_state_t;

endpackage : aba_pkg

// ==== verilog/aba_qual_if.sv ====
// Interface between the arbitration master and its grant qualifier
`timescale 1ns/1ps
`default_nettype none
interface aba_qual_if;
	logic grantN;
	logic busyOther;
	logic startN;
	logic extStartN;
	logic ackN;
	logic retryN;
	logic retryOwn;
	logic retryExcl;
	logic selfMaster;
	logic qual;
	logic inWindow;

	modport master (
		output grantN, busyOther, startN, extStartN, ackN, retryN,
		output retryOwn, retryExcl, selfMaster,
		input  qual, inWindow
	);
	modport qualifier (
		input  grantN, busyOther, startN, extStartN, ackN, retryN,
		input  retryOwn, retryExcl, selfMaster,
		output qual, inWindow
	);
endinterface : aba_qual_if
`default_nettype wire

// ==== verilog/aba_qualifier.sv ====
// Qualified grant detection for the address bus arbitration master
`timescale 1ns/1ps
`default_nettype none
module aba_qualifier #(
	parameter bit RETRY_BYPASS = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Master side
	aba_qual_if.qualifier qi
);

	typedef struct packed {
		logic tenure;
		logic retryPrevN;
		logic ackPrevN;
	} aba_qstate_t;

	aba_qstate_t s_r;
	aba_qstate_t s_nxt;
	logic        startNow;
	logic        retryOk;
	logic        bypass;

	always_comb
	begin
		startNow = (qi.startN == aba_pkg::PIN_ASSERTED)
			|| (qi.extStartN == aba_pkg::PIN_ASSERTED);
		// Window runs from the start cycle through the acknowledge cycle
		qi.inWindow = s_r.tenure || startNow;
		retryOk = (qi.retryN == aba_pkg::PIN_NEGATED)
			&& (s_r.retryPrevN == aba_pkg::PIN_NEGATED);
		// Own retry with exclusive data may regrant right after acknowledge
		bypass = RETRY_BYPASS
			&& (s_r.ackPrevN == aba_pkg::PIN_ASSERTED)
			&& (qi.retryN == aba_pkg::PIN_ASSERTED)
			&& qi.retryOwn && qi.retryExcl;
		qi.qual = (qi.grantN == aba_pkg::PIN_ASSERTED)
			&& !qi.busyOther && !qi.inWindow && !qi.selfMaster
			&& (retryOk || bypass);
		s_nxt = s_r;
		s_nxt.tenure = qi.inWindow && (qi.ackN == aba_pkg::PIN_NEGATED);
		s_nxt.retryPrevN = qi.retryN;
		s_nxt.ackPrevN = qi.ackN;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s_r <= '{tenure: 1'b0, retryPrevN: aba_pkg::PIN_NEGATED,
				ackPrevN: aba_pkg::PIN_NEGATED};
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_window_blocks: assert property (qi.inWindow |-> !qi.qual)
		else $error("grant qualified inside address tenure window");
	a_retry_blocks: assert property ((qi.retryN == aba_pkg::PIN_NEGATED)
		##1 (qi.retryN == aba_pkg::PIN_ASSERTED) && !bypass |-> !qi.qual)
		else $error("grant qualified while retry asserted");

endmodule : aba_qualifier
`default_nettype wire

// ==== verilog/aba_arbiter.sv ====
// Address bus arbitration master: request, qualified grant, bus busy
`timescale 1ns/1ps
`default_nettype none
module aba_arbiter #(
	parameter int PIPE_MAX     = aba_pkg::PIPE_MAX_DEF,
	parameter bit LOW_POWER    = 1'b0,
	parameter bit RETRY_BYPASS = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Arbitration pins, active low; addressBusBusyOe is an active-high enable
	output var  logic addressBusRequestN,
	input  wire logic addressBusGrantN,
	input  wire logic addressBusBusyInN,
	output var  logic addressBusBusyOutN,
	output var  logic addressBusBusyOe,
	// Tenure pins observed, active low
	input  wire logic transferStartN,
	input  wire logic extendedTransferStartN,
	input  wire logic addressAcknowledgeN,
	input  wire logic addressRetryN,
	// Core side requests
	input  wire logic txnPending,
	input  wire logic txnCancel,
	input  wire logic oneShotReq,
	input  wire logic retryOwn,
	input  wire logic retryExclusive,
	input  wire logic dataDone,
	// Core side status
	output var  logic mastershipTaken,
	output var  logic isMaster,
	output var  logic pipeFull
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (PIPE_MAX < aba_pkg::PIPE_MIN || PIPE_MAX > (1 << aba_pkg::CNT_W) - 1)
	begin : g_bad_pipe
		$error("PIPE_MAX out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		aba_pkg::aba_state_t              state;
		logic                             reqN;
		logic                             busyOutN;
		logic                             busyOe;
		logic [aba_pkg::GAP_W-1:0]        gap;
		logic                             take;
		logic                             master;
		logic [aba_pkg::CNT_W-1:0]        outstanding;
		logic                             full;
	} aba_mstate_t;

	localparam logic [aba_pkg::CNT_W-1:0] CNT_ONE  = 2'h1;
	localparam logic [aba_pkg::CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [aba_pkg::CNT_W-1:0] CNT_MAX  = aba_pkg::CNT_W'(PIPE_MAX);

	aba_mstate_t s_r;
	aba_mstate_t s_nxt;
	logic        accept;
	logic        wantReq;
	logic        retryGap;
	logic        pulseReq;
	logic        ackNow;

	aba_qual_if qi ();

	// ------------------------------------------------------------
	// Qualifier hookup
	// ------------------------------------------------------------
	assign qi.grantN     = addressBusGrantN;
	// Wire low only through another master while we do not pull it low
	assign qi.busyOther  = (addressBusBusyInN == aba_pkg::PIN_ASSERTED)
		&& !(s_r.busyOe && s_r.busyOutN == aba_pkg::PIN_ASSERTED);
	assign qi.startN     = transferStartN;
	assign qi.extStartN  = extendedTransferStartN;
	assign qi.ackN       = addressAcknowledgeN;
	assign qi.retryN     = addressRetryN;
	assign qi.retryOwn   = retryOwn;
	assign qi.retryExcl  = retryExclusive;
	// No fresh qualification while this tenure runs
	assign qi.selfMaster = s_r.master;

	aba_qualifier #(
		.RETRY_BYPASS (RETRY_BYPASS)
	) u_qual (
		.clk_sys (clk_sys),
		.rst     (rst),
		.qi      (qi.qualifier)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.take = 1'b0;
		ackNow = (addressAcknowledgeN == aba_pkg::PIN_ASSERTED);
		// Parked grant needs no request; a cancel declines it
		accept = qi.qual && txnPending && !txnCancel;
		wantReq = txnPending && !txnCancel && !accept;
		retryGap = (addressRetryN == aba_pkg::PIN_ASSERTED) && !retryOwn;
		pulseReq = LOW_POWER && oneShotReq && !retryGap;

		if (s_r.gap != aba_pkg::GAP_NONE)
			s_nxt.gap = s_r.gap - aba_pkg::GAP_STEP;

		case (s_r.state)
			aba_pkg::ST_IDLE, aba_pkg::ST_REQ, aba_pkg::ST_REL:
			begin
				s_nxt.busyOutN = aba_pkg::PIN_NEGATED;
				s_nxt.busyOe = 1'b0;
				if (accept)
				begin
					// Taken next cycle whatever grant does then
					s_nxt.state = aba_pkg::ST_OWN;
					s_nxt.busyOutN = aba_pkg::PIN_ASSERTED;
					s_nxt.busyOe = 1'b1;
					s_nxt.take = 1'b1;
					s_nxt.master = 1'b1;
					s_nxt.gap = aba_pkg::GAP_AFTER_GRANT;
				end
				else if (wantReq)
					s_nxt.state = aba_pkg::ST_REQ;
				else
					s_nxt.state = aba_pkg::ST_IDLE;
			end
			aba_pkg::ST_OWN:
			begin
				if (ackNow)
				begin
					// Drive high one cycle, then let go
					s_nxt.state = aba_pkg::ST_REL;
					s_nxt.busyOutN = aba_pkg::PIN_NEGATED;
					s_nxt.busyOe = 1'b1;
					s_nxt.master = 1'b0;
				end
				else
				begin
					s_nxt.busyOutN = aba_pkg::PIN_ASSERTED;
					s_nxt.busyOe = 1'b1;
				end
			end
			default:
			begin
				s_nxt.state = aba_pkg::ST_IDLE;
				s_nxt.busyOutN = aba_pkg::PIN_NEGATED;
				s_nxt.busyOe = 1'b0;
				s_nxt.master = 1'b0;
			end
		endcase

		// Request pin
		if (pulseReq)
			s_nxt.reqN = aba_pkg::PIN_ASSERTED;
		else if (accept || s_nxt.gap != aba_pkg::GAP_NONE)
			s_nxt.reqN = aba_pkg::PIN_NEGATED;
		else if (retryGap)
			s_nxt.reqN = aba_pkg::PIN_NEGATED;
		else if (wantReq)
			s_nxt.reqN = aba_pkg::PIN_ASSERTED;
		else
			s_nxt.reqN = aba_pkg::PIN_NEGATED;

		// Outstanding pipelined tenures, for status only
		if (s_r.take && !dataDone)
		begin
			if (s_r.outstanding != CNT_MAX)
				s_nxt.outstanding = s_r.outstanding + CNT_ONE;
		end
		else if (!s_r.take && dataDone)
		begin
			if (s_r.outstanding != CNT_ZERO)
				s_nxt.outstanding = s_r.outstanding - CNT_ONE;
		end
		s_nxt.full = (s_nxt.outstanding >= CNT_MAX);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s_r.state <= aba_pkg::ST_IDLE;
			s_r.reqN <= aba_pkg::PIN_NEGATED;
			s_r.busyOutN <= aba_pkg::PIN_NEGATED;
			s_r.busyOe <= 1'b0;
			s_r.gap <= aba_pkg::GAP_NONE;
			s_r.take <= 1'b0;
			s_r.master <= 1'b0;
			s_r.outstanding <= CNT_ZERO;
			s_r.full <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign addressBusRequestN = s_r.reqN;
	assign addressBusBusyOutN = s_r.busyOutN;
	assign addressBusBusyOe   = s_r.busyOe;
	assign mastershipTaken    = s_r.take;
	assign isMaster           = s_r.master;
	assign pipeFull           = s_r.full;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_req_gap_take: assert property (mastershipTaken && !$past(pulseReq)
		|-> addressBusRequestN == aba_pkg::PIN_NEGATED)
		else $error("request asserted in the cycle after taking the bus");

	a_busy_after_qual: assert property (qi.qual && txnPending && !txnCancel
		|=> addressBusBusyOe && addressBusBusyOutN == aba_pkg::PIN_ASSERTED
			&& mastershipTaken)
		else $error("bus busy not asserted after accepted grant");

	a_busy_held: assert property (isMaster
		|-> addressBusBusyOe && addressBusBusyOutN == aba_pkg::PIN_ASSERTED)
		else $error("bus busy not held while master");

	a_decline_grant: assert property (qi.qual && txnCancel
		|=> !mastershipTaken && addressBusBusyOutN == aba_pkg::PIN_NEGATED)
		else $error("declined grant drove bus busy");

	a_busy_release: assert property (isMaster
		&& addressAcknowledgeN == aba_pkg::PIN_ASSERTED
		|=> addressBusBusyOutN == aba_pkg::PIN_NEGATED && addressBusBusyOe
		##1 !addressBusBusyOe || mastershipTaken)
		else $error("bus busy not released after acknowledge");

	a_other_busy: assert property (qi.busyOther |=> !mastershipTaken)
		else $error("bus taken while another master holds it busy");

	a_retry_drop: assert property (
		addressRetryN == aba_pkg::PIN_ASSERTED && !retryOwn
		|=> addressBusRequestN == aba_pkg::PIN_NEGATED)
		else $error("request not dropped after retry");

	a_cancel_drop: assert property (txnCancel && !pulseReq
		|=> addressBusRequestN == aba_pkg::PIN_NEGATED)
		else $error("request kept after cancel");

	a_one_shot: assert property (pulseReq |=> addressBusRequestN == aba_pkg::PIN_ASSERTED)
		else $error("one-shot request missing");

	a_master_noqual: assert property (isMaster |-> !qi.qual)
		else $error("grant qualified while already master");

	a_reset_quiet: assert property ($past(rst)
		|-> addressBusRequestN == aba_pkg::PIN_NEGATED && !addressBusBusyOe)
		else $error("request or bus busy active after reset");

	// ------------------------------------------------------------
	// Pin-level checks of taking the bus, of bus busy and of the request, and covers
	// ------------------------------------------------------------
	a_take_granted: assert property (mastershipTaken
		|-> $past(addressBusGrantN) == aba_pkg::PIN_ASSERTED)
		else $error("bus taken without grant in the previous cycle");

	a_grant_dropped: assert property (qi.qual && txnPending && !txnCancel
		##1 addressBusGrantN == aba_pkg::PIN_NEGATED |-> mastershipTaken)
		else $error("bus not taken after grant dropped");

	a_park_take: assert property (qi.qual && txnPending && !txnCancel
		&& addressBusRequestN == aba_pkg::PIN_NEGATED |=> mastershipTaken)
		else $error("parked grant not accepted");

	a_take_retry: assert property (mastershipTaken
		|-> ($past(addressRetryN) == aba_pkg::PIN_NEGATED
			&& $past(addressRetryN, 2) == aba_pkg::PIN_NEGATED)
			|| (RETRY_BYPASS && $past(retryOwn) && $past(retryExclusive)))
		else $error("bus taken around an address retry");

	a_take_no_start: assert property (mastershipTaken
		|-> $past(transferStartN) == aba_pkg::PIN_NEGATED
			&& $past(extendedTransferStartN) == aba_pkg::PIN_NEGATED)
		else $error("bus taken in a transfer start cycle");

	a_take_pulse: assert property (mastershipTaken |=> !mastershipTaken)
		else $error("mastership taken twice in a row");

	a_cancel_no_take: assert property (txnCancel |=> !mastershipTaken)
		else $error("bus taken for a cancelled transaction");

	a_busy_only_master: assert property (addressBusBusyOe
		&& addressBusBusyOutN == aba_pkg::PIN_ASSERTED |-> isMaster)
		else $error("bus busy driven while not master");

	a_busy_oe_one: assert property (addressBusBusyOe && !isMaster
		|=> !addressBusBusyOe || isMaster)
		else $error("bus busy held after release cycle");

	a_full_keeps_req: assert property (pipeFull && txnPending && !txnCancel
		&& addressRetryN == aba_pkg::PIN_NEGATED
		&& addressBusGrantN == aba_pkg::PIN_NEGATED
		|=> addressBusRequestN == aba_pkg::PIN_ASSERTED)
		else $error("request withheld while pipeline full");

	c_parked_take: cover property (addressBusRequestN == aba_pkg::PIN_NEGATED
		##1 mastershipTaken);
	c_requested_take: cover property (addressBusRequestN == aba_pkg::PIN_ASSERTED
		##1 mastershipTaken);
	c_tenure_done: cover property (isMaster ##1 !isMaster ##1 !addressBusBusyOe);
	c_declined: cover property (qi.qual && txnCancel);
	c_bypass_take: cover property (addressRetryN == aba_pkg::PIN_ASSERTED && retryOwn
		##1 mastershipTaken);

endmodule : aba_arbiter
`default_nettype wire

// ==== verif/aba_partner_model.sv ====
// Far-side model: arbiter, tenure target and other bus masters
`timescale 1ns/1ps
`default_nettype none
module aba_partner_model #(
	parameter int ACK_DELAY = 2
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Bench commands
	input  wire logic grantOn,
	input  wire logic otherBusy,
	input  wire logic otherStart,
	input  wire logic retryOn,
	// Device pins seen
	input  wire logic mastershipTaken,
	input  wire logic busyOutN,
	input  wire logic busyOe,
	// Pins driven, active low
	output logic      grantN,
	output logic      busyOtherN,
	output logic      startN,
	output logic      extStartN,
	output logic      ackN,
	output logic      retryN
);
	logic [3:0] ackCnt_r;

	assign grantN     = !grantOn;
	assign busyOtherN = !(otherBusy && !(busyOe && !busyOutN));
	assign startN     = !mastershipTaken;
	assign extStartN  = !otherStart;
	assign retryN     = !retryOn;
	assign ackN       = (ackCnt_r != 4'h1);

	// Acknowledge a fixed delay after any start
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ackCnt_r <= 4'h0;
		else if (!startN || !extStartN)
			ackCnt_r <= 4'(ACK_DELAY);
		else if (ackCnt_r != 4'h0)
			ackCnt_r <= ackCnt_r - 4'h1;
	end
endmodule : aba_partner_model
`default_nettype wire

// ==== verif/address_bus_arbitration_master_bench.sv ====
// Self-checking bench of the address bus arbitration master
`timescale 1ns/1ps
`default_nettype none
module address_bus_arbitration_master_bench;
	logic clk_sys, rst, requestN, grantN, busyInN, busyOutN, busyOe;
	logic startN, extStartN, ackN, retryN, busyOtherN;
	logic pending, cancel, oneShot, retryOwn, retryExcl, dataDone;
	logic taken, isMaster, pipeFull;
	logic grantOn, otherBusy, otherStart, retryOn;
	int   n_fail, samples_checked, cycles;

	// Busy wire: pull-up, any driver pulls low
	assign busyInN = ((busyOe && !busyOutN) || !busyOtherN) ? 1'h0 : 1'h1;

	// Variants enabled; oneShot and retryExcl stay idle outside t_variants
	aba_arbiter #(.LOW_POWER(1'h1), .RETRY_BYPASS(1'h1)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.addressBusRequestN(requestN),
		.addressBusGrantN(grantN), .addressBusBusyInN(busyInN),
		.addressBusBusyOutN(busyOutN), .addressBusBusyOe(busyOe),
		.transferStartN(startN), .extendedTransferStartN(extStartN),
		.addressAcknowledgeN(ackN), .addressRetryN(retryN), .txnPending(pending),
		.txnCancel(cancel), .oneShotReq(oneShot), .retryOwn(retryOwn),
		.retryExclusive(retryExcl), .dataDone(dataDone), .mastershipTaken(taken),
		.isMaster(isMaster), .pipeFull(pipeFull));

	aba_partner_model #(.ACK_DELAY(2)) partner_u (.clk_sys(clk_sys), .rst(rst),
		.grantOn(grantOn), .otherBusy(otherBusy), .otherStart(otherStart),
		.retryOn(retryOn), .mastershipTaken(taken), .busyOutN(busyOutN),
		.busyOe(busyOe), .grantN(grantN), .busyOtherN(busyOtherN), .startN(startN),
		.extStartN(extStartN), .ackN(ackN), .retryN(retryN));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic cyc();
		@(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic chk(input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tenure_end();
		for (int i = 0; i < 10 && isMaster !== 1'h0; i++)
			cyc();
		cyc();
	endtask : tenure_end

	task automatic drain();
		dataDone = 1'h1;
		repeat (3) cyc();
		dataDone = 1'h0;
		cyc();
	endtask : drain

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_walk();
		chk(requestN, 1'h1);
		chk(busyOe, 1'h0);
		chk(isMaster, 1'h0);
		pending = 1'h1;
		cyc();
		chk(requestN, 1'h0);
		grantOn = 1'h1;
		cyc();
		grantOn = 1'h0;
		pending = 1'h0;
		chk(taken, 1'h1);
		chk(busyOutN, 1'h0);
		chk(busyOe, 1'h1);
		chk(requestN, 1'h1);
		repeat (2) cyc();
		chk(busyOutN, 1'h0);
		cyc();
		chk(busyOutN, 1'h1);
		chk(isMaster, 1'h0);
		cyc();
		chk(busyOe, 1'h0);
		drain();
		$display("test walk done");
	endtask : t_walk

	task automatic t_park_busy();
		grantOn = 1'h1;
		pending = 1'h1;
		cyc();
		chk(taken, 1'h1);
		chk(requestN, 1'h1);
		grantOn = 1'h0;
		pending = 1'h0;
		tenure_end();
		otherBusy = 1'h1;
		grantOn = 1'h1;
		pending = 1'h1;
		repeat (3)
		begin
			cyc();
			chk(taken, 1'h0);
		end
		chk(requestN, 1'h0);
		otherBusy = 1'h0;
		cyc();
		chk(taken, 1'h1);
		grantOn = 1'h0;
		pending = 1'h0;
		tenure_end();
		drain();
		$display("test park and busy done");
	endtask : t_park_busy

	task automatic t_retry();
		grantOn = 1'h1;
		pending = 1'h1;
		retryOn = 1'h1;
		cyc();
		retryOn = 1'h0;
		chk(requestN, 1'h1);
		chk(taken, 1'h0);
		cyc();
		chk(taken, 1'h0);
		cyc();
		chk(taken, 1'h1);
		grantOn = 1'h0;
		pending = 1'h0;
		tenure_end();
		retryOn = 1'h1;
		retryOwn = 1'h1;
		pending = 1'h1;
		cyc();
		chk(requestN, 1'h0);
		retryOn = 1'h0;
		retryOwn = 1'h0;
		cancel = 1'h1;
		grantOn = 1'h1;
		cyc();
		chk(requestN, 1'h1);
		cyc();
		chk(taken, 1'h0);
		chk(busyOutN, 1'h1);
		cancel = 1'h0;
		pending = 1'h0;
		grantOn = 1'h0;
		drain();
		$display("test retry and cancel done");
	endtask : t_retry

	task automatic t_window();
		otherStart = 1'h1;
		grantOn = 1'h1;
		pending = 1'h1;
		for (int i = 1; i <= 4; i++)
		begin
			cyc();
			otherStart = 1'h0;
			chk(taken, 1'(i == 4));
		end
		grantOn = 1'h0;
		pending = 1'h0;
		tenure_end();
		drain();
		$display("test window done");
	endtask : t_window

	task automatic t_pipe();
		grantOn = 1'h1;
		pending = 1'h1;
		for (int i = 0; i < 9; i++)
		begin
			cyc();
			chk(taken, 1'(i % 4 == 0));
		end
		grantOn = 1'h0;
		tenure_end();
		chk(pipeFull, 1'h1);
		chk(requestN, 1'h0);
		pending = 1'h0;
		drain();
		chk(pipeFull, 1'h0);
		$display("test pipeline done");
	endtask : t_pipe

	task automatic t_variants();
		oneShot = 1'h1;
		cyc();
		chk(requestN, 1'h0);
		oneShot = 1'h0;
		cyc();
		chk(requestN, 1'h1);
		grantOn = 1'h1;
		pending = 1'h1;
		cyc();
		chk(taken, 1'h1);
		grantOn = 1'h0;
		pending = 1'h0;
		repeat (3) cyc();
		chk(isMaster, 1'h0);
		{retryOn, retryOwn, retryExcl, grantOn, pending} = 5'h1F;
		cyc();
		chk(taken, 1'h1);
		{retryOn, retryOwn, retryExcl, grantOn, pending} = 5'h00;
		tenure_end();
		drain();
		$display("test variants done");
	endtask : t_variants

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			test_done();
		end
	end

	initial
	begin
		{rst, pending, cancel, oneShot, retryOwn, retryExcl, dataDone} = 7'h40;
		{grantOn, otherBusy, otherStart, retryOn} = 4'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'h0;
		cyc();
		t_walk();
		t_park_busy();
		t_retry();
		t_window();
		t_pipe();
		t_variants();
		test_done();
	end
endmodule : address_bus_arbitration_master_bench
`default_nettype wire
